// ===== cpu_bus_cycle_sequencer.sv
// Machine-cycle sequencer and external bus pins of an 8-bit processor.
// Assumes an APB master on pclk issues cycles; pins of the outside bus are resolved by the bench.
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

module cpu_bus_cycle_sequencer
  import cpu_bus_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] addr_out,
  output logic addr_oe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic memory_request_n,
  output logic io_request_n,
  output logic read_strobe_n,
  output logic store_strobe_n,
  output logic strobe_oe,
  output logic first_cycle_marker,
  output logic refresh_strobe_n,
  output logic stopped_state_flag,
  output logic bus_grant_n,
  input wire logic maskable_irq_n,
  input wire logic nonmaskable_irq_n,
  input wire logic not_ready_stall_in,
  input wire logic bus_request_n
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [3:0] pin_raw;
  logic [3:0] sync1_ff, sync2_ff, sync3_ff, pin_ff;
  logic nmi_prev_ff, nmi_fall, nmi_pend_ff;
  seq_state_t state_ff, nxt_state;
  logic ph_ff, nxt_ph;
  logic [2:0] rst_cnt_ff;
  logic [1:0] auto_cnt_ff;
  logic stall_lo_ff;
  cmd_t cur_ff, cmd_ff, l_cmd, nk_cmd;
  logic cmd_valid_ff;
  logic boundary_ff, snap_irq_ff, snap_nmi_ff;
  logic decide, launch, take_nmi, take_irq, take_cmd, bnd, in_end, irq_seen, nmi_seen;
  logic cur_first, cur_fetchlike, nk_first, nk_fetchlike, pre3, enter_t3;
  seq_state_t fin_st;
  logic [15:0] pc_ff;
  logic [7:0] refresh_ff, ivec_ff, rd_data_ff, vec_ff;
  logic irq_en_ff, halted_ff;
  logic [1:0] mode_ff;
  strobe_t strobe_ff, nxt_strobe;
  logic [15:0] addr_ff, nxt_addr;
  logic addr_oe_ff, nxt_addr_oe, data_oe_ff, nxt_data_oe, strobe_oe_ff, nxt_strobe_oe;
  logic [7:0] data_out_ff;
  logic grant_n_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic apb_wr, apb_setup, mapped;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  assign pin_raw = {bus_request_n, not_ready_stall_in, nonmaskable_irq_n, maskable_irq_n};

  // A level counts only once the second and third stages agree.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_ff <= PINS_IDLE;
      sync2_ff <= PINS_IDLE;
      sync3_ff <= PINS_IDLE;
      pin_ff <= PINS_IDLE;
    end
    else
    begin
      sync1_ff <= pin_raw;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pin_ff <= (sync2_ff & sync3_ff) | (pin_ff & (sync2_ff ^ sync3_ff));
    end
  end

  // The non-maskable input is edge triggered, so a pending bit remembers it.
  assign nmi_fall = nmi_prev_ff & ~pin_ff[PIN_NMI];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nmi_prev_ff <= 1'b1;
      nmi_pend_ff <= 1'b0;
    end
    else
    begin
      nmi_prev_ff <= pin_ff[PIN_NMI];
      if (nmi_fall)
        nmi_pend_ff <= 1'b1;
      else if (take_nmi)
        nmi_pend_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  assign cur_fetchlike = (cur_ff.kind == CYC_FETCH) || (cur_ff.kind == CYC_HALT) || (cur_ff.kind == CYC_NMI_ACK);
  assign cur_first = cur_fetchlike || (cur_ff.kind == CYC_INT_ACK);
  assign fin_st = cur_first ? ST_T4 : ST_T3;
  assign in_end = (state_ff == ST_T3) || (state_ff == ST_T4);
  assign bnd = in_end ? (cur_ff.last || (cur_ff.kind == CYC_HALT)) : boundary_ff;
  assign irq_seen = in_end ? snap_irq_ff : ~pin_ff[PIN_IRQ];
  assign nmi_seen = in_end ? snap_nmi_ff : nmi_pend_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_ph = ~ph_ff;
    decide = 1'b0;
    launch = 1'b0;
    take_nmi = 1'b0;
    take_irq = 1'b0;
    take_cmd = 1'b0;
    l_cmd = cur_ff;
    unique case (state_ff)
      ST_RESET_WAIT: decide = (rst_cnt_ff == RESET_WAIT_LAST);
      ST_IDLE: decide = 1'b1;
      ST_GRANT: decide = 1'b1;
      ST_T1: if (ph_ff) nxt_state = ST_T2;
      // Automatic waits come first, then requested waits; at least three states always pass.
      ST_T2: if (ph_ff) nxt_state = (auto_cnt_ff != 2'h0) ? ST_TWA : (stall_lo_ff ? ST_TW : ST_T3);
      ST_TWA: if (ph_ff) nxt_state = (auto_cnt_ff > 2'h1) ? ST_TWA : (stall_lo_ff ? ST_TW : ST_T3);
      ST_TW: if (ph_ff) nxt_state = stall_lo_ff ? ST_TW : ST_T3;
      ST_T3:
        if (ph_ff)
        begin
          if (cur_first)
            nxt_state = ST_T4;
          else
            decide = 1'b1;
        end
      ST_T4: if (ph_ff) decide = 1'b1;
      default: nxt_state = ST_IDLE;
    endcase
    if (decide)
    begin
      nxt_ph = 1'b0;
      nxt_state = ST_IDLE;
      if (!pin_ff[PIN_BUS_CLAIM])
        nxt_state = ST_GRANT;
      else if (bnd && nmi_seen)
      begin
        take_nmi = 1'b1;
        l_cmd = {CYC_NMI_ACK, 1'b0, pc_ff, 8'h00};
      end
      else if (bnd && irq_seen && irq_en_ff)
      begin
        take_irq = 1'b1;
        l_cmd = {CYC_INT_ACK, 1'b0, pc_ff, 8'h00};
      end
      else if (halted_ff)
        l_cmd = {CYC_HALT, 1'b1, pc_ff, 8'h00};
      else if (cmd_valid_ff)
      begin
        take_cmd = 1'b1;
        l_cmd = cmd_ff;
        if ((cmd_ff.kind == CYC_FETCH) || (cmd_ff.kind == CYC_HALT))
          l_cmd.addr = pc_ff;
      end
      launch = take_nmi || take_irq || take_cmd || (halted_ff && pin_ff[PIN_BUS_CLAIM]);
      if (launch)
        nxt_state = ST_T1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_RESET_WAIT;
      ph_ff <= 1'b0;
      rst_cnt_ff <= 3'h0;
      cur_ff <= CMD_RESET;
      auto_cnt_ff <= 2'h0;
      boundary_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ph_ff <= nxt_ph;
      if (state_ff == ST_RESET_WAIT)
        rst_cnt_ff <= rst_cnt_ff + 3'h1;
      if (decide)
        boundary_ff <= launch ? 1'b0 : bnd;
      if (launch)
      begin
        cur_ff <= l_cmd;
        if ((l_cmd.kind == CYC_IO_RD) || (l_cmd.kind == CYC_IO_WR))
          auto_cnt_ff <= AUTO_WAITS_IO;
        else if (l_cmd.kind == CYC_INT_ACK)
          auto_cnt_ff <= AUTO_WAITS_INTA;
        else
          auto_cnt_ff <= 2'h0;
      end
      else if ((state_ff == ST_TWA) && ph_ff)
        auto_cnt_ff <= auto_cnt_ff - 2'h1;
    end
  end

  // Stall is looked at in the middle of every state that may precede state three.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stall_lo_ff <= 1'b0;
    else if (!ph_ff && ((state_ff == ST_T2) || (state_ff == ST_TWA) || (state_ff == ST_TW)))
      stall_lo_ff <= ~pin_ff[PIN_STALL];
  end

  // Interrupt levels are frozen as the final state of the cycle begins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      snap_irq_ff <= 1'b0;
      snap_nmi_ff <= 1'b0;
    end
    else if ((nxt_state == fin_st) && (state_ff != fin_st) && !launch)
    begin
      snap_irq_ff <= ~pin_ff[PIN_IRQ];
      snap_nmi_ff <= nmi_pend_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Processor state
  // ----------------------------------------------------------------------
  assign enter_t3 = (nxt_state == ST_T3) && (state_ff != ST_T3);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_ff <= PC_RESET;
      refresh_ff <= REFRESH_RESET;
      rd_data_ff <= 8'h00;
      vec_ff <= 8'h00;
    end
    else
    begin
      if (enter_t3 && (cur_ff.kind == CYC_FETCH))
      begin
        rd_data_ff <= data_in;
        pc_ff <= pc_ff + 16'h0001;
      end
      if (enter_t3 && (cur_ff.kind == CYC_INT_ACK))
        vec_ff <= data_in;
      if ((state_ff == ST_T3) && !ph_ff && ((cur_ff.kind == CYC_MEM_RD) || (cur_ff.kind == CYC_IO_RD)))
        rd_data_ff <= data_in;
      if ((state_ff == ST_T4) && ph_ff)
      begin
        refresh_ff <= {refresh_ff[7], refresh_ff[6:0] + 7'h01};
        if (cur_ff.kind == CYC_NMI_ACK)
          pc_ff <= PC_NMI;
        else if ((cur_ff.kind == CYC_INT_ACK) && (mode_ff == MODE_ONE))
          pc_ff <= PC_MODE_ONE;
      end
      // A software jump overrides the hardware update in the same cycle.
      if (apb_wr && (paddr == REG_PC))
        pc_ff <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_en_ff <= 1'b0;
      mode_ff <= MODE_RESET;
      ivec_ff <= IVEC_RESET;
      halted_ff <= 1'b0;
      cmd_valid_ff <= 1'b1;
      cmd_ff <= CMD_RESET;
    end
    else
    begin
      if (apb_wr && (paddr == REG_CTRL))
      begin
        irq_en_ff <= pwdata[CTRL_IEF_BIT];
        mode_ff <= pwdata[CTRL_MODE_LSB +: 2];
        ivec_ff <= pwdata[CTRL_IVEC_LSB +: 8];
      end
      if (take_nmi || take_irq)
        irq_en_ff <= 1'b0;
      if (take_nmi || take_irq)
        halted_ff <= 1'b0;
      else if (take_cmd && (cmd_ff.kind == CYC_HALT))
        halted_ff <= 1'b1;
      if (take_cmd)
        cmd_valid_ff <= 1'b0;
      else if (apb_wr && (paddr == REG_CMD) && !cmd_valid_ff)
      begin
        cmd_valid_ff <= 1'b1;
        cmd_ff.kind <= cyc_kind_t'(pwdata[CMD_KIND_LSB +: 3]);
        cmd_ff.last <= pwdata[CMD_LAST_BIT];
        cmd_ff.wdata <= pwdata[CMD_WDATA_LSB +: 8];
        cmd_ff.addr <= pwdata[CMD_ADDR_LSB +: 16];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin decode
  // ----------------------------------------------------------------------
  assign nk_cmd = launch ? l_cmd : cur_ff;
  assign nk_fetchlike = (nk_cmd.kind == CYC_FETCH) || (nk_cmd.kind == CYC_HALT) || (nk_cmd.kind == CYC_NMI_ACK);
  assign nk_first = nk_fetchlike || (nk_cmd.kind == CYC_INT_ACK);
  assign pre3 = (nxt_state == ST_T2) || (nxt_state == ST_TWA) || (nxt_state == ST_TW);

  // Strobes are computed for the coming half state and registered, so pins never glitch.
  always_comb
  begin
    nxt_strobe = STROBE_IDLE;
    nxt_addr = nk_cmd.addr;
    nxt_addr_oe = 1'b1;
    nxt_strobe_oe = 1'b1;
    nxt_data_oe = 1'b0;
    if (nk_first && ((nxt_state == ST_T1) || pre3))
      nxt_strobe.first_n = 1'b0;
    if (nk_fetchlike && (((nxt_state == ST_T1) && nxt_ph) || pre3))
    begin
      nxt_strobe.mem_n = 1'b0;
      nxt_strobe.rd_n = 1'b0;
    end
    if (nk_first && ((nxt_state == ST_T3) || (nxt_state == ST_T4)))
    begin
      nxt_strobe.refresh_n = 1'b0;
      nxt_addr = {ivec_ff, refresh_ff};
      if (((nxt_state == ST_T3) && nxt_ph) || ((nxt_state == ST_T4) && !nxt_ph))
        nxt_strobe.mem_n = 1'b0;
    end
    if (((nk_cmd.kind == CYC_MEM_RD) || (nk_cmd.kind == CYC_MEM_WR))
        && (((nxt_state == ST_T1) && nxt_ph) || pre3 || ((nxt_state == ST_T3) && !nxt_ph)))
    begin
      nxt_strobe.mem_n = 1'b0;
      nxt_strobe.rd_n = (nk_cmd.kind != CYC_MEM_RD);
    end
    if ((nk_cmd.kind == CYC_MEM_WR) && (((nxt_state == ST_T2) && nxt_ph) || (nxt_state == ST_TW)
        || ((nxt_state == ST_T3) && !nxt_ph)))
      nxt_strobe.wr_n = 1'b0;
    if (((nk_cmd.kind == CYC_IO_RD) || (nk_cmd.kind == CYC_IO_WR)) && (pre3 || ((nxt_state == ST_T3) && !nxt_ph)))
    begin
      nxt_strobe.io_n = 1'b0;
      nxt_strobe.rd_n = (nk_cmd.kind != CYC_IO_RD);
      nxt_strobe.wr_n = (nk_cmd.kind != CYC_IO_WR);
    end
    if ((nk_cmd.kind == CYC_INT_ACK) && ((nxt_state == ST_TWA) || (nxt_state == ST_TW)))
      nxt_strobe.io_n = 1'b0;
    if (((nk_cmd.kind == CYC_MEM_WR) || (nk_cmd.kind == CYC_IO_WR))
        && (((nxt_state == ST_T1) && nxt_ph) || pre3 || (nxt_state == ST_T3)))
      nxt_data_oe = 1'b1;
    if ((nxt_state == ST_GRANT) || (nxt_state == ST_RESET_WAIT))
    begin
      nxt_addr_oe = 1'b0;
      nxt_strobe_oe = 1'b0;
      nxt_data_oe = 1'b0;
    end
  end

  // A stopped pclk simply holds every flop, so pins and state freeze and resume unchanged.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strobe_ff <= STROBE_IDLE;
      addr_ff <= PC_RESET;
      addr_oe_ff <= 1'b0;
      strobe_oe_ff <= 1'b0;
      data_oe_ff <= 1'b0;
      data_out_ff <= 8'h00;
      grant_n_ff <= 1'b1;
    end
    else
    begin
      strobe_ff <= nxt_strobe;
      addr_ff <= nxt_addr;
      addr_oe_ff <= nxt_addr_oe;
      strobe_oe_ff <= nxt_strobe_oe;
      data_oe_ff <= nxt_data_oe;
      data_out_ff <= nk_cmd.wdata;
      // Grant follows the float by one pclk, and is also withdrawn one pclk after our drivers turn back on.
      grant_n_ff <= (state_ff != ST_GRANT);
    end
  end

  assign addr_out = addr_ff;
  assign addr_oe = addr_oe_ff;
  assign data_out = data_out_ff;
  assign data_oe = data_oe_ff;
  assign memory_request_n = strobe_ff.mem_n;
  assign io_request_n = strobe_ff.io_n;
  assign read_strobe_n = strobe_ff.rd_n;
  assign store_strobe_n = strobe_ff.wr_n;
  assign first_cycle_marker = strobe_ff.first_n;
  assign refresh_strobe_n = strobe_ff.refresh_n;
  assign strobe_oe = strobe_oe_ff;
  assign stopped_state_flag = ~halted_ff;
  assign bus_grant_n = grant_n_ff;

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && !pslverr;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_CMD) || (paddr == REG_STATUS) || (paddr == REG_PC);
  assign pready = 1'b1;
  // A command written while one is still queued is refused rather than overwriting it.
  assign pslverr = psel && penable && (!mapped || (pwrite && (paddr == REG_CMD) && cmd_valid_ff));

  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    if (paddr == REG_CTRL)
      nxt_prdata = {16'h0000, ivec_ff, 5'h00, mode_ff, irq_en_ff};
    else if (paddr == REG_CMD)
      nxt_prdata = {cmd_ff.addr, cmd_ff.wdata, 4'h0, cmd_ff.last, cmd_ff.kind};
    else if (paddr == REG_STATUS)
      nxt_prdata = {vec_ff, refresh_ff, rd_data_ff, state_ff, nmi_pend_ff, ~grant_n_ff, halted_ff, cmd_valid_ff};
    else if (paddr == REG_PC)
      nxt_prdata = {16'h0000, pc_ff};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (apb_setup)
      prdata_ff <= nxt_prdata;
  end

  assign prdata = prdata_ff;

endmodule : cpu_bus_cycle_sequencer

// ===== cpu_bus_pkg.sv
// Constants, field positions and types of the bus cycle sequencer.
// Assumes one clock pclk at 10 MHz and an APB master with 32-bit data.

package cpu_bus_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned PCLK_PERIOD_NS = 100;
  // One processor state is two pclk halves, so a half state is one pclk.
  localparam int unsigned HALVES_PER_STATE = 2;
  localparam int unsigned RESET_IDLE_STATES = 2;
  localparam logic [2:0] RESET_WAIT_LAST = 3'(RESET_IDLE_STATES * HALVES_PER_STATE - 1);
  localparam logic [1:0] AUTO_WAITS_IO = 2'h1;
  localparam logic [1:0] AUTO_WAITS_INTA = 2'h2;

  // ----------------------------------------------------------------------
  // Addresses and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] PC_NMI = 16'h0066;
  localparam logic [15:0] PC_MODE_ONE = 16'h0038;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_ONE = 2'h1;
  localparam logic [7:0] IVEC_RESET = 8'h00;
  localparam logic [7:0] REFRESH_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0c;
  localparam int unsigned CTRL_IEF_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam int unsigned CTRL_IVEC_LSB = 8;
  localparam int unsigned CMD_KIND_LSB = 0;
  localparam int unsigned CMD_LAST_BIT = 3;
  localparam int unsigned CMD_WDATA_LSB = 8;
  localparam int unsigned CMD_ADDR_LSB = 16;

  // Synchronised pin positions.
  localparam int unsigned PIN_IRQ = 0;
  localparam int unsigned PIN_NMI = 1;
  localparam int unsigned PIN_STALL = 2;
  localparam int unsigned PIN_BUS_CLAIM = 3;
  localparam logic [3:0] PINS_IDLE = 4'hf;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET_WAIT = 4'h0,
    ST_IDLE = 4'h1,
    ST_T1 = 4'h2,
    ST_T2 = 4'h3,
    ST_TWA = 4'h4,
    ST_TW = 4'h5,
    ST_T3 = 4'h6,
    ST_T4 = 4'h7,
    ST_GRANT = 4'h8
  } seq_state_t;

  typedef enum logic [2:0] {
    CYC_FETCH = 3'h0,
    CYC_MEM_RD = 3'h1,
    CYC_MEM_WR = 3'h2,
    CYC_IO_RD = 3'h3,
    CYC_IO_WR = 3'h4,
    CYC_INT_ACK = 3'h5,
    CYC_NMI_ACK = 3'h6,
    CYC_HALT = 3'h7
  } cyc_kind_t;

  typedef struct packed {
    logic mem_n;
    logic io_n;
    logic rd_n;
    logic wr_n;
    logic first_n;
    logic refresh_n;
  } strobe_t;

  localparam strobe_t STROBE_IDLE = 6'h3f;

  typedef struct packed {
    cyc_kind_t kind;
    logic last;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cmd_t;

  // The first fetch after reset is queued by reset itself.
  localparam cmd_t CMD_RESET = {CYC_FETCH, 1'b0, PC_RESET, 8'h00};

endpackage : cpu_bus_pkg

// ===== far_side_model.sv
// Memory, port and interrupting device facing the sequencer pins.
// Assumes outputs of the sequencer are registered on pclk.
`timescale 1ns/1ps
module far_side_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] addr_out,
  input wire logic memory_request_n,
  input wire logic io_request_n,
  input wire logic read_strobe_n,
  input wire logic first_cycle_marker,
  input wire logic [3:0] waits,
  output logic [7:0] data_in,
  output logic not_ready_stall_in
);
  logic [3:0] cnt_ff;
  logic [7:0] last_ff;
  // The pin needs four clocks through the synchroniser, so an armed stall is already low before
  // the strobe and lasts waits clocks into it; otherwise the wait stage would never see it.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt_ff <= 4'h0;
    else if (memory_request_n && io_request_n) cnt_ff <= 4'h0;
    else if (cnt_ff != 4'hf) cnt_ff <= cnt_ff + 4'h1;
  assign not_ready_stall_in = !(cnt_ff < waits);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) last_ff <= 8'h00;
    else last_ff <= data_in;
  // An undriven bus shows a toggling pattern so a stale byte is never mistaken for data.
  always_comb
    if (!io_request_n && !first_cycle_marker) data_in = 8'hc3;
    else if (!read_strobe_n) data_in = addr_out[7:0] ^ 8'h5a;
    else data_in = ~last_ff;
endmodule : far_side_model

// ===== seq_props.sv
// Pin timing checker of the bus cycle sequencer.
// Assumes it is bound to the sequencer top, one clock pclk.
`timescale 1ns/1ps
module seq_props
  import cpu_bus_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] addr_out,
  input wire logic addr_oe,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic memory_request_n,
  input wire logic io_request_n,
  input wire logic read_strobe_n,
  input wire logic store_strobe_n,
  input wire logic strobe_oe,
  input wire logic first_cycle_marker,
  input wire logic refresh_strobe_n,
  input wire logic stopped_state_flag,
  input wire logic bus_grant_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_float_fetch: assert property ($rose(presetn) |-> (!addr_oe && !strobe_oe && !data_oe)[*3]
    ##[1:3] (addr_oe && addr_out == PC_RESET && !first_cycle_marker)) else $error("reset exit");
  chk_mem_after_addr: assert property ($fell(memory_request_n) && !first_cycle_marker |->
    $past(first_cycle_marker) == 1'b0 && $stable(addr_out)) else $error("memory request early");
  chk_refresh_t34: assert property ($fell(refresh_strobe_n) |-> first_cycle_marker && read_strobe_n
    ##1 (!memory_request_n && !refresh_strobe_n)[*2] ##1 memory_request_n) else $error("refresh");
  chk_store_data_stable: assert property ($fell(store_strobe_n) |->
    data_oe && $past(data_oe) && $stable(data_out)) else $error("store data");
  chk_io_auto_wait: assert property ($fell(io_request_n) && first_cycle_marker |->
    (!io_request_n && memory_request_n && !(read_strobe_n && store_strobe_n))[*4]) else $error("io wait");
  chk_ack_two_waits: assert property ($fell(io_request_n) && !first_cycle_marker |->
    (!io_request_n && memory_request_n)[*4]) else $error("ack waits");
  chk_grant_floated: assert property ($fell(bus_grant_n) |->
    !addr_oe && !strobe_oe && !data_oe && $past(strobe_oe) == 1'b0) else $error("grant");
  chk_halt_nop_run: assert property ($fell(stopped_state_flag) |->
    !first_cycle_marker ##[1:10] !refresh_strobe_n) else $error("halt nop");
  cover property ($fell(bus_grant_n));
  cover property ($fell(stopped_state_flag));
  cover property ($fell(io_request_n) && !first_cycle_marker);
endmodule : seq_props

// ===== tb_cpu_bus_cycle_sequencer.sv
// Self-checking bench of the bus cycle sequencer.
// Assumes the far side model and the checker beside it.
`timescale 1ns/1ps
module tb_cpu_bus_cycle_sequencer;
  import cpu_bus_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, addr_oe, data_oe, strobe_oe, err;
  logic memory_request_n, io_request_n, read_strobe_n, store_strobe_n, first_cycle_marker;
  logic refresh_strobe_n, stopped_state_flag, bus_grant_n, maskable_irq_n, nonmaskable_irq_n;
  logic not_ready_stall_in, bus_request_n;
  logic [7:0] paddr, data_in, data_out;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] addr_out;
  logic [3:0] waits;
  int bad_count, compares, c, k;
  cpu_bus_cycle_sequencer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .addr_out, .addr_oe, .data_in, .data_out, .data_oe, .memory_request_n,
    .io_request_n, .read_strobe_n, .store_strobe_n, .strobe_oe, .first_cycle_marker, .refresh_strobe_n,
    .stopped_state_flag, .bus_grant_n, .maskable_irq_n, .nonmaskable_irq_n, .not_ready_stall_in, .bus_request_n);
  far_side_model far_u (.pclk, .presetn, .addr_out, .memory_request_n, .io_request_n, .read_strobe_n,
    .first_cycle_marker, .waits, .data_in, .not_ready_stall_in);
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task summarize;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask : chk
  task guard(input int n);
    if (n >= 200)
    begin
      bad_count++;
      summarize();
    end
  endtask : guard
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 200);
    guard(n);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wait_idle;
    int n;
    n = 0;
    do begin apb(1'b0, REG_STATUS, 32'h0); n++; end while ((rd[7:4] !== ST_IDLE || rd[0] !== 1'b0) && n < 200);
    guard(n);
  endtask : wait_idle
  task io_len(input logic w);
    c = 0; k = 0;
    while (io_request_n !== 1'b0 && k < 200) begin @(negedge pclk); k++; end
    chk(addr_out[7:0], 8'h34);
    chk(data_oe, w);
    if (w) chk(data_out, 8'ha5);
    while (io_request_n === 1'b0 && k < 200) begin @(negedge pclk); c++; k++; end
    guard(k);
  endtask : io_len
  task t_reset;
    wait_idle();
    chk(rd[23:8], 16'h015a);
    apb(1'b0, REG_PC, 32'h0); chk(rd, 32'h1);
    apb(1'b0, REG_CTRL, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0); chk(rd, 32'h0); chk(err, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task t_io;
    apb(1'b1, REG_CMD, 32'h1234_a504); io_len(1'b1); chk(c, 5);
    waits <= 4'h4;
    apb(1'b1, REG_CMD, 32'h1234_0003); io_len(1'b0); chk(c > 5, 1'b1);
    waits <= 4'h0;
    wait_idle(); chk(rd[15:8], 8'h6e);
    $display("io test done");
  endtask : t_io
  task t_irq;
    @(posedge pclk) maskable_irq_n <= 1'b0;
    apb(1'b1, REG_CMD, 32'h0200_0009); wait_idle();
    apb(1'b0, REG_PC, 32'h0); chk(rd, 32'h1);
    apb(1'b1, REG_CTRL, 32'h3); wait_idle();
    maskable_irq_n <= 1'b1;
    apb(1'b0, REG_PC, 32'h0); chk(rd, 32'h38);
    apb(1'b0, REG_STATUS, 32'h0); chk(rd[31:24], 8'hc3);
    apb(1'b0, REG_CTRL, 32'h0); chk(rd, 32'h2);
    $display("irq test done");
  endtask : t_irq
  task pulse_nmi;
    @(posedge pclk) nonmaskable_irq_n <= 1'b0;
    repeat (8) @(posedge pclk);
    nonmaskable_irq_n <= 1'b1;
  endtask : pulse_nmi
  task t_halt;
    apb(1'b1, REG_CMD, 32'h7);
    k = 0;
    while (stopped_state_flag !== 1'b0 && k < 200) begin @(negedge pclk); k++; end
    guard(k); chk(stopped_state_flag, 1'b0);
    pulse_nmi(); wait_idle(); chk(rd[1], 1'b0);
    apb(1'b0, REG_PC, 32'h0); chk(rd, 32'h66);
    $display("halt test done");
  endtask : t_halt
  task t_bus;
    apb(1'b1, REG_PC, 32'h0100);
    // A last cycle first, so the pending NMI later finds an instruction boundary.
    apb(1'b1, REG_CMD, 32'h0200_0009); wait_idle();
    bus_request_n <= 1'b0;
    k = 0;
    while (bus_grant_n !== 1'b0 && k < 200) begin @(negedge pclk); k++; end
    guard(k); chk({addr_oe, strobe_oe, data_oe}, 3'h0);
    // While the bus is handed over a command waits in the queue, so a second one is refused.
    apb(1'b1, REG_CMD, 32'h0300_5a02); chk(err, 1'b0);
    apb(1'b1, REG_CMD, 32'h0000_0000); chk(err, 1'b1);
    pulse_nmi(); apb(1'b0, REG_STATUS, 32'h0); chk(rd[3:2], 2'h3);
    bus_request_n <= 1'b1;
    wait_idle(); apb(1'b0, REG_PC, 32'h0); chk(rd, 32'h66);
    $display("bus test done");
  endtask : t_bus
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, waits} = '0;
    {maskable_irq_n, nonmaskable_irq_n, bus_request_n} = 3'h7;
    presetn = 1'b0; bad_count = 0; compares = 0;
    repeat (3 * HALVES_PER_STATE) @(posedge pclk);
    presetn <= 1'b1;
    t_reset(); t_io(); t_irq(); t_halt(); t_bus();
    summarize();
  end
endmodule : tb_cpu_bus_cycle_sequencer
bind cpu_bus_cycle_sequencer seq_props chk_u (.pclk, .presetn, .addr_out, .addr_oe, .data_out, .data_oe,
  .memory_request_n, .io_request_n, .read_strobe_n, .store_strobe_n, .strobe_oe, .first_cycle_marker,
  .refresh_strobe_n, .stopped_state_flag, .bus_grant_n);
